/* design/sss_pkg.sv */
package sss_pkg;

  // Clock and millisecond timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] ADDR_POWER_OFF_SEQ = 8'h00;
  localparam logic [7:0] ADDR_UV_TRIP       = 8'h04;
  localparam logic [7:0] ADDR_DETECT_TIME   = 8'h08;
  localparam logic [7:0] ADDR_ALARM_SEQ     = 8'h0C;
  localparam logic [7:0] ADDR_STATUS        = 8'h10;

  // Reset values
  localparam logic [15:0] RST_POWER_OFF_SEQ = 16'h0000;
  localparam logic [15:0] RST_UV_TRIP       = 16'h0001;
  localparam logic [15:0] RST_DETECT_TIME   = 16'h0046;
  localparam logic [15:0] RST_ALARM_SEQ     = 16'h0000;

  // Legal ranges and special values
  localparam logic [15:0] POWER_OFF_SEQ_MAX = 16'h0009;
  localparam logic [15:0] UV_TRIP_MAX       = 16'h0001;
  localparam logic [15:0] DETECT_MIN        = 16'h0046;
  localparam logic [15:0] DETECT_MAX        = 16'h07D0;
  localparam logic [15:0] DETECT_DISABLE    = 16'h03E8;
  localparam logic [15:0] ALARM_SEQ_MAX     = 16'h0007;
  localparam logic [15:0] STOP_SPEED        = 16'h001E;
  localparam logic [3:0]  SEQ_AB_MIN        = 4'h4;
  localparam logic [3:0]  SEQ_ESTOP_MIN     = 4'h8;

  // Braking action
  typedef enum logic [1:0] {
    ACT_BRAKE = 2'b00,
    ACT_FREE  = 2'b01,
    ACT_ESTOP = 2'b10
  } sss_action_t;

  // Stop sequence state
  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_DECEL   = 2'b01,
    ST_STOPPED = 2'b10
  } sss_state_t;

  // Status register layout, low bits
  typedef struct packed {
    logic       uvError;
    logic       offDetected;
    logic       alarmMode;
    sss_state_t state;
  } sss_status_t;

endpackage : sss_pkg

/* design/sss_seq_if.sv */
`timescale 1ns/1ps
interface sss_seq_if;
  import sss_pkg::*;
  logic [3:0]  seqValue;
  logic        alarmTable;
  logic        estopAlarm;
  sss_action_t decelAction;
  sss_action_t afterAction;
  logic        clearOnStop;

  modport requester (output seqValue, alarmTable, estopAlarm,
                     input decelAction, afterAction, clearOnStop);
  modport decoder (input seqValue, alarmTable, estopAlarm,
                   output decelAction, afterAction, clearOnStop);
endinterface : sss_seq_if

/* design/sss_action_decode.sv */
`timescale 1ns/1ps
module sss_action_decode
  import sss_pkg::*;
(
  // Sequence selection
  sss_seq_if.decoder seq
);

  // Bit 0 picks the deceleration action, bit 1 the after-stop action
  always_comb
  begin
    seq.decelAction = seq.seqValue[0] ? ACT_FREE : ACT_BRAKE;
    seq.afterAction = seq.seqValue[1] ? ACT_FREE : ACT_BRAKE;
    seq.clearOnStop = 1'b1;
    if (seq.alarmTable)
    begin
      if (seq.seqValue >= SEQ_AB_MIN && seq.estopAlarm)
        seq.decelAction = ACT_ESTOP;
    end
    else if (seq.seqValue >= SEQ_ESTOP_MIN)
    begin
      // Settings 8 and 9 stop hard, then brake or run free
      seq.decelAction = ACT_ESTOP;
      seq.afterAction = seq.seqValue[0] ? ACT_FREE : ACT_BRAKE;
    end
    else
      seq.clearOnStop = seq.seqValue < SEQ_AB_MIN;
  end

endmodule : sss_action_decode

/* design/sss_absence_timer.sv */
`timescale 1ns/1ps
module sss_absence_timer
  import sss_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Supply state and programmed time
  input  wire logic        supplyAbsent,
  input  wire logic [15:0] detectTime,
  // Result
  output logic             powerOffDetected
);

  localparam int PW = $clog2(CYCLES_PER_MS + 1);

  logic [PW-1:0] prescale;
  logic [PW-1:0] next_prescale;
  logic [15:0]   msCount;
  logic [15:0]   next_msCount;
  logic          next_detected;

  // Count whole milliseconds of continuous absence
  always_comb
  begin
    next_prescale = prescale;
    next_msCount  = msCount;
    if (!supplyAbsent)
    begin
      next_prescale = '0;
      next_msCount  = '0;
    end
    else if (prescale == PW'(CYCLES_PER_MS - 1))
    begin
      next_prescale = '0;
      if (msCount != 16'hFFFF)
        next_msCount = msCount + 16'h0001;
    end
    else
      next_prescale = prescale + PW'(1);
    next_detected = supplyAbsent && detectTime != DETECT_DISABLE
                    && msCount >= detectTime;
  end

  // State registers
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      prescale         <= '0;
      msCount          <= '0;
      powerOffDetected <= 1'b0;
    end
    else
    begin
      prescale         <= next_prescale;
      msCount          <= next_msCount;
      powerOffDetected <= next_detected;
    end
  end

  a_return_clears : assert property (@(posedge clock) disable iff (reset)
    !supplyAbsent |=> !powerOffDetected)
    else $error("detection stayed with supply present");
  a_disable_value : assert property (@(posedge clock) disable iff (reset)
    detectTime == DETECT_DISABLE |=> !powerOffDetected)
    else $error("detection active at disable setting");

endmodule : sss_absence_timer

/* design/sss_top.sv */
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Power-off sequence accepts 0 to 9 and maps them like the servo-off sequence.
// - With trip selection 0, power loss at servo-on follows the power-off sequence.
// - With trip selection 1, the default, power loss at servo-on trips on undervoltage.
// - Trip selection has no effect while detection time is 1000.
// - Bus voltage low before power-off is detected trips undervoltage regardless.
// - Power-off is declared only after the programmed continuous absence, 70 to 2000 ms.
// - The detection time value 1000 disables power-off detection.
// - Alarm settings 4 to 7 stop hard when the alarm demands an emergency stop.
// - Otherwise settings 4 and 6 brake and 5 and 7 run free while slowing.
// - Deviation is held during an alarm and cleared when the alarm is cancelled.
// - Deceleration ends at 30 r/min and the after-stop action then applies.
// - Detection time changes take effect only at the next control power-on.
module sss_top
  import sss_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Supply monitor pins
  input  wire logic        mainPowerPresent,
  input  wire logic        lowSupplyBus,
  input  wire logic        controlPowerGood,
  // Drive state from control logic
  input  wire logic        servoOn,
  input  wire logic        alarmActive,
  input  wire logic        alarmNeedsEstop,
  input  wire logic        alarmCancel,
  input  wire logic [15:0] motorSpeed,
  // Power stage and error outputs
  output logic             shortedWindingBrake,
  output logic             freeRun,
  output logic             emergencyStop,
  output logic             mainUndervoltageError,
  output logic             mainUndervoltageErrorSub1,
  output logic             holdDeviation,
  output logic             clearDeviation,
  output logic             powerOffDetected
);

  logic [1:0]  presentSync;
  logic [1:0]  busLowSync;
  logic [1:0]  ctrlSync;
  logic        ctrlPrev;
  logic [15:0] powerOffSeq;
  logic [15:0] uvTripSel;
  logic [15:0] detectTime;
  logic [15:0] alarmSeq;
  logic [15:0] activeTime;
  logic [15:0] next_powerOffSeq;
  logic [15:0] next_uvTripSel;
  logic [15:0] next_detectTime;
  logic [15:0] next_alarmSeq;
  logic [15:0] next_activeTime;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        inRange;
  logic        mapped;
  logic        setupPhase;
  logic        accessPhase;
  logic [31:0] readMux;
  sss_status_t status;
  sss_state_t  state;
  sss_state_t  next_state;
  logic        alarmMode;
  logic        next_alarmMode;
  logic        uvError;
  logic        next_uvError;
  logic        tripEnabled;
  logic        tripEvent;
  logic        effAlarm;
  logic        powerRise;
  sss_action_t act;
  logic        next_brake;
  logic        next_free;
  logic        next_estop;
  logic        next_hold;
  logic        next_clear;

  sss_seq_if seq ();

  // Two-stage synchronisers for the pins
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      presentSync <= 2'h0;
      busLowSync  <= 2'h0;
      ctrlSync    <= 2'h0;
      ctrlPrev    <= 1'b0;
    end
    else
    begin
      presentSync <= {presentSync[0], mainPowerPresent};
      busLowSync  <= {busLowSync[0], lowSupplyBus};
      ctrlSync    <= {ctrlSync[0], controlPowerGood};
      ctrlPrev    <= ctrlSync[1];
    end
  end

  assign powerRise = ctrlSync[1] & ~ctrlPrev;

  // Continuous-absence timer on the latched detection time
  sss_absence_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_timer (
    .clock            (clock),
    .reset            (reset),
    .supplyAbsent     (~presentSync[1]),
    .detectTime       (activeTime),
    .powerOffDetected (powerOffDetected)
  );

  // Action table lookup
  assign seq.seqValue   = alarmMode ? alarmSeq[3:0] : powerOffSeq[3:0];
  assign seq.alarmTable = alarmMode;
  assign seq.estopAlarm = alarmNeedsEstop;

  sss_action_decode u_decode (
    .seq (seq.decoder)
  );

  // APB decode; zero wait states
  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign pready      = 1'b1;
  assign status      = '{uvError, powerOffDetected, alarmMode, state};

  always_comb
  begin
    mapped  = 1'b1;
    inRange = 1'b1;
    readMux = 32'h0000_0000;
    unique case (paddr)
      ADDR_POWER_OFF_SEQ:
      begin
        readMux = {16'h0000, powerOffSeq};
        inRange = pwdata[31:16] == 16'h0000 && pwdata[15:0] <= POWER_OFF_SEQ_MAX;
      end
      ADDR_UV_TRIP:
      begin
        readMux = {16'h0000, uvTripSel};
        inRange = pwdata[31:16] == 16'h0000 && pwdata[15:0] <= UV_TRIP_MAX;
      end
      ADDR_DETECT_TIME:
      begin
        readMux = {16'h0000, detectTime};
        inRange = pwdata[31:16] == 16'h0000 && pwdata[15:0] >= DETECT_MIN
                  && pwdata[15:0] <= DETECT_MAX;
      end
      ADDR_ALARM_SEQ:
      begin
        readMux = {16'h0000, alarmSeq};
        inRange = pwdata[31:16] == 16'h0000 && pwdata[15:0] <= ALARM_SEQ_MAX;
      end
      ADDR_STATUS:
      begin
        readMux = {27'h0000000, status};
        inRange = 1'b0;
      end
      default:
        mapped = 1'b0;
    endcase
  end

  // Register file next values
  always_comb
  begin
    next_powerOffSeq = powerOffSeq;
    next_uvTripSel   = uvTripSel;
    next_detectTime  = detectTime;
    next_alarmSeq    = alarmSeq;
    next_prdata      = prdata;
    next_pslverr     = pslverr;
    next_activeTime  = powerRise ? detectTime : activeTime;
    if (setupPhase)
    begin
      next_prdata  = readMux;
      next_pslverr = ~mapped | (pwrite & ~inRange);
    end
    if (accessPhase && pwrite && mapped && inRange)
    begin
      unique case (paddr)
        ADDR_POWER_OFF_SEQ: next_powerOffSeq = pwdata[15:0];
        ADDR_UV_TRIP:       next_uvTripSel   = pwdata[15:0];
        ADDR_DETECT_TIME:   next_detectTime  = pwdata[15:0];
        ADDR_ALARM_SEQ:     next_alarmSeq    = pwdata[15:0];
        default:            next_prdata      = prdata;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      powerOffSeq <= RST_POWER_OFF_SEQ;
      uvTripSel   <= RST_UV_TRIP;
      detectTime  <= RST_DETECT_TIME;
      alarmSeq    <= RST_ALARM_SEQ;
      activeTime  <= RST_DETECT_TIME;
      prdata      <= 32'h0000_0000;
      pslverr     <= 1'b0;
    end
    else
    begin
      powerOffSeq <= next_powerOffSeq;
      uvTripSel   <= next_uvTripSel;
      detectTime  <= next_detectTime;
      alarmSeq    <= next_alarmSeq;
      activeTime  <= next_activeTime;
      prdata      <= next_prdata;
      pslverr     <= next_pslverr;
    end
  end

  // Undervoltage trip and stop sequence next values
  always_comb
  begin
    tripEnabled = uvTripSel[0] && activeTime != DETECT_DISABLE;
    tripEvent   = (powerOffDetected && servoOn && tripEnabled)
                  || (busLowSync[1] && !powerOffDetected);
    next_uvError = tripEvent | (uvError & ~alarmCancel);
    effAlarm       = alarmActive | uvError;
    next_state     = state;
    next_alarmMode = alarmMode;
    unique case (state)
      ST_RUN:
      begin
        if (effAlarm)
        begin
          next_state     = ST_DECEL;
          next_alarmMode = 1'b1;
        end
        else if (powerOffDetected && servoOn && !tripEnabled)
        begin
          next_state     = ST_DECEL;
          next_alarmMode = 1'b0;
        end
      end
      ST_DECEL:
      begin
        if (effAlarm)
          next_alarmMode = 1'b1;
        if (motorSpeed <= STOP_SPEED)
          next_state = ST_STOPPED;
      end
      ST_STOPPED:
      begin
        if (effAlarm)
          next_alarmMode = 1'b1;
        else if (alarmMode || !powerOffDetected)
          next_state = ST_RUN;
      end
      default:
        next_state = ST_RUN;
    endcase
    // Braking outputs follow the phase of the stop
    act        = (state == ST_DECEL) ? seq.decelAction : seq.afterAction;
    next_brake = state != ST_RUN && act == ACT_BRAKE;
    next_free  = state != ST_RUN && act == ACT_FREE;
    next_estop = state == ST_DECEL && act == ACT_ESTOP;
    next_hold  = effAlarm
                 || (state != ST_RUN && !alarmMode && !seq.clearOnStop);
    next_clear = (alarmCancel && holdDeviation)
                 || (state == ST_STOPPED && !alarmMode && seq.clearOnStop);
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state               <= ST_RUN;
      alarmMode           <= 1'b0;
      uvError             <= 1'b0;
      shortedWindingBrake <= 1'b0;
      freeRun             <= 1'b0;
      emergencyStop       <= 1'b0;
      holdDeviation       <= 1'b0;
      clearDeviation      <= 1'b0;
    end
    else
    begin
      state               <= next_state;
      alarmMode           <= next_alarmMode;
      uvError             <= next_uvError;
      shortedWindingBrake <= next_brake;
      freeRun             <= next_free;
      emergencyStop       <= next_estop;
      holdDeviation       <= next_hold;
      clearDeviation      <= next_clear;
    end
  end

  assign mainUndervoltageError     = uvError;
  assign mainUndervoltageErrorSub1 = uvError;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_alarm_decel;
    state == ST_DECEL && alarmMode && alarmSeq[3:0] >= SEQ_AB_MIN;
  endsequence

  a_trip_enabled : assert property (
    powerOffDetected && servoOn && uvTripSel[0] && activeTime != DETECT_DISABLE
    |=> mainUndervoltageError)
    else $error("no undervoltage trip at power loss");
  a_trip_disabled : assert property (
    !uvTripSel[0] && !busLowSync[1] && !uvError && !$past(uvError) |=> !uvError)
    else $error("undervoltage raised with trip off");
  a_bus_low_trip : assert property (
    busLowSync[1] && !powerOffDetected |=> uvError)
    else $error("bus low did not trip");
  a_reject_alarm : assert property (
    accessPhase && pwrite && paddr == ADDR_ALARM_SEQ && pwdata[15:0] > ALARM_SEQ_MAX
    |=> alarmSeq == $past(alarmSeq))
    else $error("illegal alarm sequence stored");
  a_decel_end : assert property (
    state == ST_DECEL && motorSpeed <= STOP_SPEED |=> state == ST_STOPPED)
    else $error("deceleration did not end at stop speed");
  a_estop_alarm : assert property (
    s_alarm_decel ##0 alarmNeedsEstop |=> emergencyStop)
    else $error("no emergency stop for alarm");
  a_no_estop_b : assert property (
    s_alarm_decel ##0 !alarmNeedsEstop |=> !emergencyStop
    && (shortedWindingBrake == !$past(alarmSeq[0])))
    else $error("wrong action B");
  a_hold_alarm : assert property (
    effAlarm |=> holdDeviation)
    else $error("deviation not held in alarm");
  a_cancel_clear : assert property (
    alarmCancel && holdDeviation |=> clearDeviation)
    else $error("deviation not cleared on cancel");
  a_time_latched : assert property (
    !powerRise |=> activeTime == $past(activeTime))
    else $error("detection time changed without power-on");

endmodule : sss_top

/* bench/sss_supply_model.sv */
`timescale 1ns/1ps
module sss_supply_model
(
  // Clock
  input  wire logic        clock,
  // Bench commands
  input  wire logic        powerOn,
  input  wire logic        busLow,
  input  wire logic        ctrlCycle,
  input  wire logic        loadSpeed,
  input  wire logic [15:0] startSpeed,
  // Power stage drive from the block
  input  wire logic        brakeOn,
  input  wire logic        freeOn,
  input  wire logic        estopOn,
  // Monitor pins towards the block
  output logic             mainPowerPresent,
  output logic             lowSupplyBus,
  output logic             controlPowerGood,
  output logic [15:0]      motorSpeed
);
  logic [2:0] offCount;

  // Supply present, bus healthy, control power good at start
  initial
  begin
    offCount = 3'h0;
    mainPowerPresent = 1'b1;
    lowSupplyBus = 1'b0;
    controlPowerGood = 1'b1;
    motorSpeed = 16'h0000;
  end

  // Pins follow commands; a control power cycle dips for a few cycles
  always @(posedge clock)
  begin
    mainPowerPresent <= powerOn;
    lowSupplyBus     <= busLow;
    if (ctrlCycle)
      offCount <= 3'h6;
    else if (offCount != 3'h0)
      offCount <= offCount - 3'h1;
    controlPowerGood <= (offCount == 3'h0) && !ctrlCycle;
    // Motor slows one step a cycle while any stop action acts on it
    if (loadSpeed)
      motorSpeed <= startSpeed;
    else if ((brakeOn || freeOn || estopOn) && motorSpeed != 16'h0000)
      motorSpeed <= motorSpeed - 16'h0001;
  end
endmodule : sss_supply_model

/* bench/tb_stop_sequence_selector.sv */
`timescale 1ns/1ps
module tb_stop_sequence_selector;
  import sss_pkg::*;
  localparam int CPM = 10;
  logic        clock, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        mainPowerPresent, lowSupplyBus, controlPowerGood, servoOn;
  logic        alarmActive, alarmNeedsEstop, alarmCancel;
  logic [15:0] motorSpeed, startSpeed;
  logic        shortedWindingBrake, freeRun, emergencyStop, mainUndervoltageError;
  logic        mainUndervoltageErrorSub1, holdDeviation, clearDeviation;
  logic        powerOffDetected, powerOn, busLow, ctrlCycle, loadSpeed, er, e, est;
  logic [3:0]  s;
  int          nFail, checksDone, n;
  logic [7:0]  badAddr [6] = '{8'h00, 8'h04, 8'h08, 8'h08, 8'h0C, 8'h00};
  logic [31:0] badData [6] = '{32'hA, 32'h2, 32'h45, 32'h7D1, 32'h8, 32'h10000};
  logic [31:0] rstVal  [6] = '{32'h0, 32'h1, 32'h46, 32'h46, 32'h0, 32'h0};

  sss_top #(.CYCLES_PER_MS(CPM)) u_sss_top (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mainPowerPresent(mainPowerPresent),
    .lowSupplyBus(lowSupplyBus), .controlPowerGood(controlPowerGood), .servoOn(servoOn),
    .alarmActive(alarmActive), .alarmNeedsEstop(alarmNeedsEstop),
    .alarmCancel(alarmCancel), .motorSpeed(motorSpeed),
    .shortedWindingBrake(shortedWindingBrake), .freeRun(freeRun),
    .emergencyStop(emergencyStop), .mainUndervoltageError(mainUndervoltageError),
    .mainUndervoltageErrorSub1(mainUndervoltageErrorSub1),
    .holdDeviation(holdDeviation), .clearDeviation(clearDeviation),
    .powerOffDetected(powerOffDetected));

  sss_supply_model u_sss_supply_model (.clock(clock), .powerOn(powerOn), .busLow(busLow),
    .ctrlCycle(ctrlCycle), .loadSpeed(loadSpeed), .startSpeed(startSpeed),
    .brakeOn(shortedWindingBrake), .freeOn(freeRun), .estopOn(emergencyStop),
    .mainPowerPresent(mainPowerPresent), .lowSupplyBus(lowSupplyBus),
    .controlPowerGood(controlPowerGood), .motorSpeed(motorSpeed));

  // Clock at 125 MHz
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Word and flag comparisons
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checksDone++;
    if (got !== ex)
    begin
      nFail++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task chkBit(input string nm, input logic ex, input logic got);
    chk(nm, {31'h0, ex}, {31'h0, got});
  endtask : chkBit

  // One APB transfer: setup, then access until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    // pready is tied high, so this wait ends after one clock
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    chkBit("pslverr", ee, er);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk("prdata", ex, rd);
    chkBit("pslverr", 1'b0, er);
  endtask : rdc

  // Alarm cancel pulse; the alarm itself drops in the same cycle
  task cancel();
    @(posedge clock);
    alarmCancel <= 1'b1;
    alarmActive <= 1'b0;
    @(posedge clock);
    alarmCancel <= 1'b0;
  endtask : cancel

  // Drop main power, count cycles until the block declares it off
  task dropPower();
    @(posedge clock);
    powerOn <= 1'b0;
    for (n = 0; n < 900 && powerOffDetected !== 1'b1; n++)
      @(posedge clock);
  endtask : dropPower

  task complete_run();
    if (nFail == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  // Watchdog against a hung wait
  initial
  begin
    repeat (30000) @(posedge clock);
    nFail++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    nFail = 0; checksDone = 0; reset = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; servoOn = 1'b0; alarmActive = 1'b0;
    alarmNeedsEstop = 1'b0; alarmCancel = 1'b0; powerOn = 1'b1; busLow = 1'b0;
    ctrlCycle = 1'b0; loadSpeed = 1'b0; startSpeed = 16'h0028;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    // Reset values, unmapped place, refused and boundary writes
    rdc(ADDR_UV_TRIP, 32'h1);
    rdc(ADDR_DETECT_TIME, 32'h46);
    apb(1'b0, 8'h14, 32'h0);
    chkBit("unmappedErr", 1'b1, er);
    for (int i = 0; i < 6; i++)
    begin
      wr(badAddr[i], badData[i], 1'b1);
      rdc(badAddr[i], rstVal[i]);
    end
    wr(ADDR_POWER_OFF_SEQ, 32'h9, 1'b0);
    rdc(ADDR_POWER_OFF_SEQ, 32'h9);
    wr(ADDR_DETECT_TIME, 32'h7D0, 1'b0);
    rdc(ADDR_DETECT_TIME, 32'h7D0);
    // Every alarm sequence without an emergency-stop alarm, and sequences 4 to 7 with one
    for (int i = 0; i < 12; i++)
    begin
      s = (i < 8) ? 4'(i) : 4'(i - 4);
      e = (i >= 8);
      est = s[2] & e;
      wr(ADDR_ALARM_SEQ, {28'h0, s}, 1'b0);
      loadSpeed <= 1'b1;
      @(posedge clock);
      loadSpeed <= 1'b0; alarmNeedsEstop <= e; alarmActive <= 1'b1;
      repeat (4) @(posedge clock);
      chkBit("estop", est, emergencyStop);
      if (!est)
        chkBit("decelFree", s[0], freeRun);
      chkBit("hold", 1'b1, holdDeviation);
      for (n = 0; n < 60 && motorSpeed !== 16'h001F; n++)
        @(posedge clock);
      chkBit("estopAt31", est, emergencyStop);
      repeat (4) @(posedge clock);
      chkBit("afterBrake", !s[1], shortedWindingBrake);
      chkBit("afterFree", s[1], freeRun);
      chkBit("afterEstop", 1'b0, emergencyStop);
      cancel();
      for (n = 0; n < 4 && clearDeviation !== 1'b1; n++)
        @(posedge clock);
      chkBit("clear", 1'b1, clearDeviation);
      repeat (4) @(posedge clock);
      chkBit("released", 1'b0, holdDeviation);
    end
    // Power loss with default trip selection
    wr(ADDR_ALARM_SEQ, 32'h0, 1'b0);
    servoOn <= 1'b1;
    dropPower();
    chkBit("detectTime", 1'b1, n >= 70 * CPM && n < 74 * CPM);
    repeat (3) @(posedge clock);
    chkBit("uvTrip", 1'b1, mainUndervoltageError);
    chkBit("uvSub1", 1'b1, mainUndervoltageErrorSub1);
    chkBit("alarmBrake", 1'b1, shortedWindingBrake);
    powerOn <= 1'b1;
    repeat (10) @(posedge clock);
    cancel();
    repeat (3) @(posedge clock);
    chkBit("uvCleared", 1'b0, mainUndervoltageError);
    // Trip disabled: power-off sequence 5 runs free while slowing and holds deviation
    wr(ADDR_UV_TRIP, 32'h0, 1'b0);
    wr(ADDR_POWER_OFF_SEQ, 32'h5, 1'b0);
    loadSpeed <= 1'b1;
    @(posedge clock);
    loadSpeed <= 1'b0;
    dropPower();
    repeat (3) @(posedge clock);
    chkBit("noTrip", 1'b0, mainUndervoltageError);
    chkBit("offFree", 1'b1, freeRun);
    chkBit("offHold", 1'b1, holdDeviation);
    powerOn <= 1'b1;
    repeat (20) @(posedge clock);
    // Power-off sequence 8 stops hard while slowing
    wr(ADDR_POWER_OFF_SEQ, 32'h8, 1'b0);
    loadSpeed <= 1'b1;
    @(posedge clock);
    loadSpeed <= 1'b0;
    dropPower();
    repeat (3) @(posedge clock);
    chkBit("offEstop", 1'b1, emergencyStop);
    powerOn <= 1'b1;
    repeat (10) @(posedge clock);
    // Bus low before detection trips whatever the selection
    busLow <= 1'b1;
    repeat (6) @(posedge clock);
    chkBit("busTrip", 1'b1, mainUndervoltageError);
    busLow <= 1'b0;
    repeat (4) @(posedge clock);
    cancel();
    // Detection time 1000 waits for control power-on, then disables detection
    wr(ADDR_DETECT_TIME, 32'h3E8, 1'b0);
    wr(ADDR_UV_TRIP, 32'h1, 1'b0);
    dropPower();
    chkBit("oldTime", 1'b1, n >= 70 * CPM && n < 74 * CPM);
    powerOn <= 1'b1;
    repeat (10) @(posedge clock);
    cancel();
    ctrlCycle <= 1'b1;
    @(posedge clock);
    ctrlCycle <= 1'b0;
    repeat (20) @(posedge clock);
    powerOn <= 1'b0;
    // Longer than 1000 ms of absence
    repeat (10200) @(posedge clock);
    chkBit("noDetect", 1'b0, powerOffDetected);
    chkBit("tripIgnored", 1'b0, mainUndervoltageError);
    powerOn <= 1'b1;
    repeat (5) @(posedge clock);
    complete_run();
  end
endmodule : tb_stop_sequence_selector
